// ===== rtl/fcsl_pkg.sv
// Purpose: Constants and types for the flash command and security logic
// Assumes: AXI4-Lite slave, byte offsets below
// Notes:   Contract list follows
// Contract
// - Mass erase completes before command-complete sets
// - Margin command 0x75 only in special mode
// - Margin data 0x0000, 0x0005, 0x0024 select levels
// - Address before divider init sets access error
// - Byte/misaligned write or non-command register errors
// - Second address or address after command errors
// - Undefined command sets access error, or protection violation if address protected
// - Only burst allowed while buffer empty, busy
// - Secured non-secure or debug writes restricted
// - After command, only status write launching
// - Stop aborts command, purges, sets both flags
// - Stop exit only sets buffer-empty; the purge happens at stop entry
// - Reads never raise access error
// - Protection violation on protected program or erase
// - Wait mode lets commands run to completion
// - Protection writable in debug; secured special restricted
// - Four key words compared in sequence
// - All-zero and all-ones keys never match
// - Key machine locks on any illegal step
// - Key match unsecures only; refused in special debug
package fcsl_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] OFF_CLKDIV = 8'h00;
	localparam logic [7:0] OFF_CONFIG = 8'h04;
	localparam logic [7:0] OFF_PROT   = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_CMD    = 8'h10;
	localparam logic [7:0] OFF_FWIN   = 8'h14;
	localparam logic [7:0] OFF_SECU   = 8'h18;
	localparam logic [7:0] OFF_KEYWR  = 8'h1C;
	// ==========================================================
	// Field positions
	localparam int BIT_BUFE  = 7;
	localparam int BIT_DONE  = 6;
	localparam int BIT_PVIO  = 5;
	localparam int BIT_ACCE  = 4;
	localparam int BIT_KACC  = 0;
	localparam int BIT_MISAL = 16;
	localparam int BIT_KIDX  = 16;
	// ==========================================================
	// Commands
	localparam logic [7:0] CMD_ERASE_VERIFY = 8'h05;
	localparam logic [7:0] CMD_PROGRAM      = 8'h20;
	localparam logic [7:0] CMD_BURST        = 8'h25;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
	localparam logic [7:0] CMD_MASS_ERASE   = 8'h41;
	localparam logic [7:0] CMD_MARGIN       = 8'h75;
	// ==========================================================
	// Margin data codes and levels
	localparam logic [15:0] MDATA_NORMAL = 16'h0000;
	localparam logic [15:0] MDATA_M0     = 16'h0005;
	localparam logic [15:0] MDATA_M1     = 16'h0024;
	typedef enum logic [1:0] {
		MRG_NORMAL = 2'b00,
		MRG_ZERO   = 2'b01,
		MRG_ONE    = 2'b10
	} fcsl_margin_t;
	// ==========================================================
	// Security
	localparam logic [1:0]  STATE_UNSEC   = 2'b10;
	localparam logic [1:0]  KEY_ENABLED   = 2'b10;
	localparam logic [15:0] KEY_ZERO      = 16'h0000;
	localparam logic [15:0] KEY_ONES      = 16'hFFFF;
	localparam logic [1:0]  KEY_LAST      = 2'b11;
	// ==========================================================
	// Bus responses and reset values
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;
	localparam logic [6:0]  CLKDIV_RST  = 7'h00;
	// ==========================================================
	// States
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_ADDR = 2'b01,
		SEQ_CMD  = 2'b10
	} fcsl_seq_t;
	typedef enum logic [1:0] {
		KEY_IDLE   = 2'b00,
		KEY_ACTIVE = 2'b01,
		KEY_LOCK   = 2'b10
	} fcsl_key_t;
endpackage

// ===== rtl/fcsl_top.sv
// Purpose: Flash command sequencer, error detection and backdoor key unsecure
// Assumes: One 100 MHz clock, AXI4-Lite slave, mode pins asynchronous
// Notes:   Array engine is modelled by a countdown per launched command
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fcsl_top #(
	parameter int OP_CYCLES         = 64,
	parameter int MASS_ERASE_CYCLES = 20000
) (
	// Clock and reset
	input  wire  logic        CLK,
	input  wire  logic        RESET,
	// AXI4-Lite write
	input  wire  logic [7:0]  S_AXI_AWADDR,
	input  wire  logic        S_AXI_AWVALID,
	output logic              S_AXI_AWREADY,
	input  wire  logic [31:0] S_AXI_WDATA,
	input  wire  logic [3:0]  S_AXI_WSTRB,
	input  wire  logic        S_AXI_WVALID,
	output logic              S_AXI_WREADY,
	output logic [1:0]        S_AXI_BRESP,
	output logic              S_AXI_BVALID,
	input  wire  logic        S_AXI_BREADY,
	// AXI4-Lite read
	input  wire  logic [7:0]  S_AXI_ARADDR,
	input  wire  logic        S_AXI_ARVALID,
	output logic              S_AXI_ARREADY,
	output logic [31:0]       S_AXI_RDATA,
	output logic [1:0]        S_AXI_RRESP,
	output logic              S_AXI_RVALID,
	input  wire  logic        S_AXI_RREADY,
	// Nonvolatile values read from the array
	input  wire  logic [63:0] STORED_KEYS,
	input  wire  logic [7:0]  SECURITY_BYTE,
	input  wire  logic [7:0]  PROT_BYTE,
	// Mode pins
	input  wire  logic        SPECIAL_MODE,
	input  wire  logic        DEBUG_ACTIVE,
	input  wire  logic        STOP_MODE,
	input  wire  logic        WAIT_MODE,
	// Bus-side origin of the current write
	input  wire  logic        NONSECURE_SRC,
	// Array control and status
	output logic              HIGH_VOLTAGE_ON,
	output logic              ARRAY_READ_VALID,
	output fcsl_pkg::fcsl_margin_t MARGIN_LEVEL,
	output logic [7:0]        ACTIVE_CMD,
	output logic [1:0]        SECURITY_STATE,
	output logic              KEY_LOCKED
);
	import fcsl_pkg::*;

	localparam int CNT_W = $clog2(MASS_ERASE_CYCLES + 1);
	localparam logic [CNT_W-1:0] OP_LOAD   = CNT_W'(OP_CYCLES - 1);
	localparam logic [CNT_W-1:0] MASS_LOAD = CNT_W'(MASS_ERASE_CYCLES - 1);

	// ==========================================================
	// Functions
	function automatic logic cmd_known(input logic [7:0] c, input logic spc);
		cmd_known = (c == CMD_ERASE_VERIFY) || (c == CMD_PROGRAM) || (c == CMD_BURST) ||
		            (c == CMD_SECTOR_ERASE) || (c == CMD_MASS_ERASE) ||
		            ((c == CMD_MARGIN) && spc);
	endfunction

	function automatic logic addr_protected(input logic [7:0] p, input logic [15:0] a);
		addr_protected = p[a[15:13]];
	endfunction

	// ==========================================================
	// Mode pin synchronisers
	logic [3:0] pin_s1_ff;
	logic [3:0] pin_s2_ff;
	logic [3:0] pin_s3_ff;
	logic [3:0] pin_ff;
	logic       stop_d_ff;
	logic       special;
	logic       dbg;
	logic       stop_now;
	logic       wait_now;
	logic       stop_enter;
	logic       stop_exit;

	// Value changes once the second and third stages agree
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			pin_s1_ff <= 4'h0;
			pin_s2_ff <= 4'h0;
			pin_s3_ff <= 4'h0;
			pin_ff    <= 4'h0;
			stop_d_ff <= 1'b0;
		end else begin
			pin_s1_ff <= {WAIT_MODE, STOP_MODE, DEBUG_ACTIVE, SPECIAL_MODE};
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			pin_ff    <= (pin_s2_ff & pin_s3_ff) | (pin_ff & (pin_s2_ff | pin_s3_ff));
			stop_d_ff <= pin_ff[2];
		end
	end

	assign special    = pin_ff[0];
	assign dbg        = pin_ff[1];
	assign stop_now   = pin_ff[2];
	assign wait_now   = pin_ff[3];
	assign stop_enter = stop_now & ~stop_d_ff;
	assign stop_exit  = ~stop_now & stop_d_ff;

	// ==========================================================
	// AXI4-Lite slave
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic        nxt_rhit;
	logic        wr_en;
	logic        wr_hit;
	logic        hit_clkdiv;
	logic        hit_config;
	logic        hit_prot;
	logic        hit_status;
	logic        hit_cmd;
	logic        hit_fwin;
	logic        hit_key;

	// Address and data taken together
	assign wr_en         = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_ff;
	assign S_AXI_AWREADY = wr_en;
	assign S_AXI_WREADY  = wr_en;
	assign S_AXI_ARREADY = ~rvalid_ff;
	assign hit_clkdiv    = wr_en & (S_AXI_AWADDR == OFF_CLKDIV);
	assign hit_config    = wr_en & (S_AXI_AWADDR == OFF_CONFIG);
	assign hit_prot      = wr_en & (S_AXI_AWADDR == OFF_PROT);
	assign hit_status    = wr_en & (S_AXI_AWADDR == OFF_STATUS);
	assign hit_cmd       = wr_en & (S_AXI_AWADDR == OFF_CMD);
	assign hit_fwin      = wr_en & (S_AXI_AWADDR == OFF_FWIN);
	assign hit_key       = wr_en & (S_AXI_AWADDR == OFF_KEYWR);
	assign wr_hit        = hit_clkdiv | hit_config | hit_prot | hit_status | hit_cmd |
	                       hit_fwin | hit_key | (wr_en & (S_AXI_AWADDR == OFF_SECU));

	// Write response, held until bready
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (wr_en) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Read response; reads change no state
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rvalid_ff <= 1'b0;
			rresp_ff  <= RESP_OKAY;
			rdata_ff  <= 32'h0000_0000;
		end else if (S_AXI_ARVALID & ~rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= nxt_rhit ? RESP_OKAY : RESP_SLVERR;
			rdata_ff  <= nxt_rdata;
		end else if (S_AXI_RREADY) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign S_AXI_BVALID = bvalid_ff;
	assign S_AXI_BRESP  = bresp_ff;
	assign S_AXI_RVALID = rvalid_ff;
	assign S_AXI_RRESP  = rresp_ff;
	assign S_AXI_RDATA  = rdata_ff;

	// ==========================================================
	// Software registers
	logic [6:0] clkdiv_ff;
	logic       clkdiv_set_ff;
	logic       kacc_ff;
	logic [7:0] prot_ff;
	logic [7:0] sec_byte_ff;
	logic       loaded_ff;

	// Divider; a write marks it set
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			clkdiv_ff     <= CLKDIV_RST;
			clkdiv_set_ff <= 1'b0;
		end else if (hit_clkdiv) begin
			clkdiv_ff     <= S_AXI_WDATA[6:0];
			clkdiv_set_ff <= 1'b1;
		end
	end

	// Key access enable
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			kacc_ff <= 1'b0;
		end else if (hit_config) begin
			kacc_ff <= S_AXI_WDATA[BIT_KACC];
		end
	end

	// Nonvolatile bytes captured once; protection debug-writable
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			loaded_ff   <= 1'b0;
			sec_byte_ff <= 8'h00;
			prot_ff     <= 8'h00;
		end else if (!loaded_ff) begin
			loaded_ff   <= 1'b1;
			sec_byte_ff <= SECURITY_BYTE;
			prot_ff     <= PROT_BYTE;
		end else if (hit_prot && dbg) begin
			prot_ff     <= S_AXI_WDATA[7:0];
		end
	end

	// ==========================================================
	// Command write sequence
	fcsl_seq_t   seq_ff;
	fcsl_seq_t   nxt_seq;
	logic [15:0] cap_addr_ff;
	logic [15:0] cap_data_ff;
	logic [7:0]  cap_cmd_ff;
	logic        acc_set;
	logic        pv_set;
	logic        launch;
	logic        acce_ff;
	logic        pvio_ff;
	logic        bufe_ff;
	logic        done_ff;
	logic        busy_ff;
	logic        secured;
	logic [7:0]  wcmd;
	logic        prot_hit;

	assign wcmd     = S_AXI_WDATA[7:0];
	assign prot_hit = addr_protected(prot_ff, cap_addr_ff);

	// Sequence step and error events
	always_comb begin
		nxt_seq = seq_ff;
		acc_set = 1'b0;
		pv_set  = 1'b0;
		launch  = 1'b0;
		unique case (seq_ff)
			SEQ_IDLE: begin
				if (hit_fwin && bufe_ff && !acce_ff && !pvio_ff) begin
					if (!clkdiv_set_ff) begin
						acc_set = 1'b1;
					end else if (S_AXI_WSTRB != 4'hF || S_AXI_WDATA[BIT_MISAL]) begin
						acc_set = 1'b1;
					end else begin
						nxt_seq = SEQ_ADDR;
					end
				end
			end
			SEQ_ADDR: begin
				if (hit_cmd) begin
					nxt_seq = SEQ_IDLE;
					if (!cmd_known(wcmd, special)) begin
						pv_set  = prot_hit;
						acc_set = ~prot_hit;
					end else if (bufe_ff && !done_ff && wcmd != CMD_BURST) begin
						acc_set = 1'b1;
					end else if (secured && (NONSECURE_SRC || dbg || special) &&
					             wcmd != CMD_ERASE_VERIFY && wcmd != CMD_MASS_ERASE) begin
						acc_set = 1'b1;
					end else if (((wcmd == CMD_PROGRAM || wcmd == CMD_BURST ||
					               wcmd == CMD_SECTOR_ERASE) && prot_hit) ||
					             (wcmd == CMD_MASS_ERASE && prot_ff != 8'h00)) begin
						pv_set = 1'b1;
					end else begin
						nxt_seq = SEQ_CMD;
					end
				end else if (wr_en) begin
					acc_set = 1'b1;
					nxt_seq = SEQ_IDLE;
				end
			end
			SEQ_CMD: begin
				if (hit_status && S_AXI_WDATA[BIT_BUFE]) begin
					launch  = 1'b1;
					nxt_seq = SEQ_IDLE;
				end else if (wr_en) begin
					acc_set = 1'b1;
					nxt_seq = SEQ_IDLE;
				end
			end
		endcase
		if (stop_enter) begin
			nxt_seq = SEQ_IDLE;
			launch  = 1'b0;
		end
	end

	// Sequence state and captures
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			seq_ff      <= SEQ_IDLE;
			cap_addr_ff <= 16'h0000;
			cap_data_ff <= 16'h0000;
			cap_cmd_ff  <= 8'h00;
		end else begin
			seq_ff <= nxt_seq;
			if (seq_ff == SEQ_IDLE && nxt_seq == SEQ_ADDR) begin
				cap_addr_ff <= S_AXI_WDATA[31:16];
				cap_data_ff <= S_AXI_WDATA[15:0];
			end
			if (seq_ff == SEQ_ADDR && nxt_seq == SEQ_CMD) begin
				cap_cmd_ff <= wcmd;
			end
		end
	end

	// ==========================================================
	// Command buffer and array engine
	logic             pending_ff;
	logic [7:0]       pend_cmd_ff;
	logic [15:0]      pend_data_ff;
	logic [7:0]       exec_cmd_ff;
	logic [15:0]      exec_data_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic             hv_ff;
	fcsl_margin_t     margin_ff;
	logic             abort_stop;

	assign abort_stop = stop_enter & (busy_ff | pending_ff);

	// Engine runs regardless of wait mode; stop aborts and purges
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			pending_ff   <= 1'b0;
			pend_cmd_ff  <= 8'h00;
			pend_data_ff <= 16'h0000;
			exec_cmd_ff  <= 8'h00;
			exec_data_ff <= 16'h0000;
			cnt_ff       <= '0;
			busy_ff      <= 1'b0;
			hv_ff        <= 1'b0;
			bufe_ff      <= 1'b1;
			done_ff      <= 1'b1;
			margin_ff    <= MRG_NORMAL;
		end else if (stop_enter) begin
			pending_ff <= 1'b0;
			busy_ff    <= 1'b0;
			hv_ff      <= 1'b0;
			done_ff    <= 1'b1;
		end else if (stop_exit) begin
			bufe_ff <= 1'b1;
		end else begin
			if (launch) begin
				pending_ff   <= 1'b1;
				pend_cmd_ff  <= cap_cmd_ff;
				pend_data_ff <= cap_data_ff;
				bufe_ff      <= 1'b0;
			end
			if (busy_ff) begin
				if (cnt_ff != '0) begin
					cnt_ff <= cnt_ff - 1'b1;
				end else begin
					busy_ff <= 1'b0;
					if (exec_cmd_ff == CMD_MARGIN) begin
						unique case (exec_data_ff)
							MDATA_NORMAL: margin_ff <= MRG_NORMAL;
							MDATA_M0:     margin_ff <= MRG_ZERO;
							MDATA_M1:     margin_ff <= MRG_ONE;
							default:      margin_ff <= margin_ff;
						endcase
					end
					if (!pending_ff && !launch) begin
						hv_ff   <= 1'b0;
						done_ff <= 1'b1;
					end
				end
			end else if (pending_ff) begin
				pending_ff   <= 1'b0;
				busy_ff      <= 1'b1;
				exec_cmd_ff  <= pend_cmd_ff;
				exec_data_ff <= pend_data_ff;
				cnt_ff       <= (pend_cmd_ff == CMD_MASS_ERASE) ? MASS_LOAD : OP_LOAD;
				hv_ff        <= (pend_cmd_ff != CMD_ERASE_VERIFY) && (pend_cmd_ff != CMD_MARGIN);
				bufe_ff      <= 1'b1;
				done_ff      <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Error flags: hardware set wins over write-one clear
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			acce_ff <= 1'b0;
			pvio_ff <= 1'b0;
		end else begin
			acce_ff <= acc_set | abort_stop |
			           (acce_ff & ~(hit_status & S_AXI_WDATA[BIT_ACCE]));
			pvio_ff <= pv_set | (pvio_ff & ~(hit_status & S_AXI_WDATA[BIT_PVIO]));
		end
	end

	// ==========================================================
	// Backdoor key machine
	fcsl_key_t   key_ff;
	logic [1:0]  key_idx_ff;
	logic        key_prev_ff;
	logic        unsec_ff;
	logic        key_wr;
	logic [1:0]  widx;
	logic [15:0] wkey;
	logic [15:0] skey;
	logic        key_bad;

	assign widx    = S_AXI_WDATA[BIT_KIDX +: 2];
	assign wkey    = S_AXI_WDATA[15:0];
	assign skey    = STORED_KEYS[16*widx +: 16];
	assign key_wr  = hit_key && (sec_byte_ff[7:6] == KEY_ENABLED) && kacc_ff &&
	                 !(special && dbg);
	assign key_bad = (widx != key_idx_ff) || (wkey == KEY_ZERO) || (wkey == KEY_ONES) ||
	                 (wkey != skey) || key_prev_ff;

	// Lock persists until reset
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			key_ff      <= KEY_IDLE;
			key_idx_ff  <= 2'b00;
			key_prev_ff <= 1'b0;
			unsec_ff    <= 1'b0;
		end else begin
			key_prev_ff <= key_wr;
			unique case (key_ff)
				KEY_IDLE, KEY_ACTIVE: begin
					if (key_wr && key_bad) begin
						key_ff <= KEY_LOCK;
					end else if (key_wr && key_idx_ff == KEY_LAST) begin
						unsec_ff   <= 1'b1;
						key_ff     <= KEY_IDLE;
						key_idx_ff <= 2'b00;
					end else if (key_wr) begin
						key_ff     <= KEY_ACTIVE;
						key_idx_ff <= key_idx_ff + 2'b01;
					end else if (key_ff == KEY_ACTIVE && (!kacc_ff || stop_enter)) begin
						key_ff <= KEY_LOCK;
					end
				end
				KEY_LOCK: key_ff <= KEY_LOCK;
				default:  key_ff <= KEY_LOCK;
			endcase
		end
	end

	assign secured = ~unsec_ff & (sec_byte_ff[1:0] != STATE_UNSEC);

	// ==========================================================
	// Read data
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		nxt_rhit  = 1'b1;
		unique case (S_AXI_ARADDR)
			OFF_CLKDIV: nxt_rdata = {24'h00_0000, clkdiv_set_ff, clkdiv_ff};
			OFF_CONFIG: nxt_rdata = {31'h0000_0000, kacc_ff};
			OFF_PROT:   nxt_rdata = {24'h00_0000, prot_ff};
			OFF_STATUS: nxt_rdata = {24'h00_0000, bufe_ff, done_ff, pvio_ff, acce_ff,
			                         4'h0};
			OFF_CMD:    nxt_rdata = {24'h00_0000, cap_cmd_ff};
			OFF_FWIN:   nxt_rdata = {cap_addr_ff, cap_data_ff};
			OFF_SECU:   nxt_rdata = {20'h0_0000, stop_now, wait_now, dbg, special,
			                         margin_ff, unsec_ff, (key_ff == KEY_LOCK),
			                         sec_byte_ff[7:6], SECURITY_STATE};
			OFF_KEYWR:  nxt_rdata = {30'h0000_0000, key_idx_ff};
			default:    nxt_rhit  = 1'b0;
		endcase
	end

	// ==========================================================
	// Outputs
	assign HIGH_VOLTAGE_ON  = hv_ff;
	assign ARRAY_READ_VALID = ~busy_ff;
	assign MARGIN_LEVEL     = margin_ff;
	assign ACTIVE_CMD       = exec_cmd_ff;
	assign SECURITY_STATE   = unsec_ff ? STATE_UNSEC : sec_byte_ff[1:0];
	assign KEY_LOCKED       = (key_ff == KEY_LOCK);
endmodule
`default_nettype wire

// ===== verif/fcsl_chk.sv
// Purpose: Port checks for fcsl_top
// Assumes: Sees only its ports
// Notes:   Bound below
`timescale 1ns/1ps
`default_nettype none
module fcsl_chk
	import fcsl_pkg::*;
(
	// Clock and reset
	input wire logic        CLK,
	input wire logic        RESET,
	// Register bus
	input wire logic [7:0]  S_AXI_AWADDR,
	input wire logic        S_AXI_AWVALID,
	input wire logic        S_AXI_WVALID,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	// Modes and array side
	input wire logic        SPECIAL_MODE,
	input wire logic        STOP_MODE,
	input wire logic        HIGH_VOLTAGE_ON,
	input wire logic        ARRAY_READ_VALID,
	input wire logic [1:0]  MARGIN_LEVEL,
	input wire logic [1:0]  SECURITY_STATE,
	input wire logic        KEY_LOCKED
);
	// ==========================================================
	// Assertions
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);

	a_write_answered: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID |=> S_AXI_BVALID)
		else $error("no write answer");
	a_bresp_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("bresp dropped");
	a_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("rdata dropped");
	a_unmapped_err: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID && S_AXI_AWADDR > OFF_KEYWR
		|=> S_AXI_BRESP == RESP_SLVERR)
		else $error("unmapped ok");
	a_stop_hv_off: assert property (STOP_MODE [*6] |-> !HIGH_VOLTAGE_ON)
		else $error("voltage on in stop");
	a_busy_no_read: assert property (HIGH_VOLTAGE_ON |-> !ARRAY_READ_VALID)
		else $error("read valid busy");
	a_margin_special: assert property ($changed(MARGIN_LEVEL) |-> $past(SPECIAL_MODE, 4) && MARGIN_LEVEL != 2'b11)
		else $error("margin not special");
	a_lock_holds: assert property (KEY_LOCKED |=> KEY_LOCKED)
		else $error("lock released");
	a_unlock_clean: assert property ($rose(SECURITY_STATE == 2'b10) |-> !KEY_LOCKED)
		else $error("unsecured when locked");
endmodule
bind fcsl_top fcsl_chk i_fcsl_chk (.*);
`default_nettype wire

// ===== verif/fcsl_nvm.sv
// Purpose: Nonvolatile image seen by the sequencer after reset
// Assumes: Image is fixed while the part runs
// Notes:   Top eighth protected
`timescale 1ns/1ps
`default_nettype none
module fcsl_nvm (
	// Image select
	input  wire logic secured,
	// Stored contents
	output logic [63:0] keys,
	output logic [7:0]  guard_byte,
	output logic [7:0]  prot_byte
);
	// Keys avoid all-zero and all-ones words; key access enabled
	assign keys       = 64'h1357_2468_ACE0_BDF1;
	assign guard_byte = secured ? 8'h80 : 8'h82;
	assign prot_byte  = 8'h80;
endmodule
`default_nettype wire

// ===== verif/fcsl_top_test.sv
// Purpose: Self-checking bench for fcsl_top
// Assumes: Short operation counts
// Notes:   Requests held until handshake
`timescale 1ns/1ps
`default_nettype none
module fcsl_top_test;
	import fcsl_pkg::*;
	// ==========================================================
	// Bench signals
	logic         clk, rst, awv, wv, br, arv, rr, spc, dbg, stp, wt, nsrc, img;
	logic         awr, bv, arr, rv, hv, rdv, klk;
	logic [7:0]   aw, ar, acmd, gb, pb;
	logic [31:0]  wd, rdata, d;
	logic [3:0]   ws;
	logic [1:0]   bresp, rresp, resp, sst;
	logic [63:0]  keys;
	fcsl_margin_t ml;
	int           fail_count, comparisons;
	logic [15:0]  md [3] = '{MDATA_M0, MDATA_M1, MDATA_NORMAL};
	fcsl_margin_t lv [3] = '{MRG_ZERO, MRG_ONE, MRG_NORMAL};

	fcsl_top #(.OP_CYCLES(40), .MASS_ERASE_CYCLES(80)) i_fcsl_top (
		.CLK(clk), .RESET(rst), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ar),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .STORED_KEYS(keys), .SECURITY_BYTE(gb),
		.PROT_BYTE(pb), .SPECIAL_MODE(spc), .DEBUG_ACTIVE(dbg), .STOP_MODE(stp), .WAIT_MODE(wt),
		.NONSECURE_SRC(nsrc), .HIGH_VOLTAGE_ON(hv), .ARRAY_READ_VALID(rdv),
		.MARGIN_LEVEL(ml), .ACTIVE_CMD(acmd), .SECURITY_STATE(sst), .KEY_LOCKED(klk));
	fcsl_nvm i_fcsl_nvm (.secured(img), .keys(keys), .guard_byte(gb), .prot_byte(pb));

	// Clock
	always #5 clk = ~clk;

	// ==========================================================
	// Tasks
	task automatic tally_and_finish();
		$display("Counts: %0d checks, %0d bad", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, seen, exp);
		end
	endtask
	// Bounded handshake wait
	task automatic hold_until(ref logic s);
		int n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (s !== 1'b1 && n < 200);
		if (s !== 1'b1) begin
			fail_count++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF);
		aw <= a;
		wd <= v;
		ws <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		hold_until(awr);
		awv <= 1'b0;
		wv <= 1'b0;
		hold_until(bv);
		br <= 1'b1;
		@(posedge clk);
		resp = bresp;
		br <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		ar <= a;
		arv <= 1'b1;
		hold_until(arr);
		arv <= 1'b0;
		hold_until(rv);
		rr <= 1'b1;
		@(posedge clk);
		v = rdata;
		resp = rresp;
		rr <= 1'b0;
	endtask
	task automatic st(input logic [7:0] e);
		rd(OFF_STATUS, d);
		check(32'(d[7:0]), 32'(e));
	endtask
	task automatic two(input logic [15:0] fa, input logic [7:0] a, input logic [31:0] v);
		wr(OFF_FWIN, {fa, 16'h0000});
		wr(a, v);
	endtask
	task automatic cmd(input logic [15:0] v, input logic [7:0] c);
		wr(OFF_FWIN, {16'h0000, v});
		wr(OFF_CMD, 32'(c));
		wr(OFF_STATUS, 32'h0000_0080);
	endtask
	task automatic done();
		int n = 0;
		d = '0;
		while (d[6] !== 1'b1 && n < 60) begin
			rd(OFF_STATUS, d);
			n++;
		end
		check(32'(d[6]), 32'h0000_0001);
	endtask
	task automatic boot(input logic s);
		img <= s;
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic keyseq();
		wr(OFF_CONFIG, 32'h0000_0001);
		for (int k = 0; k < 4; k++) begin
			wr(OFF_KEYWR, {14'h0000, 2'(k), keys[16*k +: 16]});
		end
		repeat (2) @(posedge clk);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{clk, awv, wv, br, arv, rr, spc, dbg, stp, wt, nsrc, img, aw, ar, wd, ws} = '0;
		rst = 1'b1;
		boot(1'b0);
		st(8'hC0);
		wr(OFF_FWIN, 32'h0000_0000);
		st(8'hD0);
		wr(OFF_STATUS, 32'h0000_0000);
		st(8'hD0);
		wr(8'h20, 32'h0000_0000);
		check(32'(resp), 32'(RESP_SLVERR));
		rd(8'h20, d);
		check(32'(resp), 32'(RESP_SLVERR));
		wr(OFF_CLKDIV, 32'h0000_0010);
		// Bad sequences raise a flag; a one clears it
		for (int i = 0; i < 13; i++) begin
			wr(OFF_STATUS, 32'h0000_0030);
			st(8'hC0);
			case (i)
				0: wr(OFF_FWIN, 32'h0000_0000, 4'h3);
				1: wr(OFF_FWIN, 32'h0001_0000);
				2: two(16'h0000, OFF_FWIN, 32'h0000_0000);
				3: two(16'h0000, OFF_CLKDIV, 32'h0000_0010);
				4: two(16'h0000, OFF_CMD, 32'h0000_0033);
				5: two(16'hE000, OFF_CMD, 32'h0000_0033);
				6: two(16'hE000, OFF_CMD, 32'(CMD_PROGRAM));
				7: two(16'hE000, OFF_CMD, 32'(CMD_SECTOR_ERASE));
				8: two(16'h0000, OFF_CMD, 32'(CMD_MASS_ERASE));
				9: two(16'h0000, OFF_CMD, 32'(CMD_MARGIN));
				10: cmd_tail(OFF_STATUS);
				11: cmd_tail(OFF_CONFIG);
				default: cmd_tail(OFF_FWIN);
			endcase
			st((i inside {5, 6, 7, 8}) ? 8'hE0 : 8'hD0);
		end
		wr(OFF_STATUS, 32'h0000_0030);
		$display("done: errors");
		// Wait keeps a program running
		cmd(16'h1234, CMD_PROGRAM);
		wt <= 1'b1;
		st(8'h80);
		two(16'h0000, OFF_CMD, 32'(CMD_PROGRAM));
		st(8'h90);
		done();
		wt <= 1'b0;
		wr(OFF_STATUS, 32'h0000_0010);
		// Stop aborts an active program
		cmd(16'h0000, CMD_PROGRAM);
		stp <= 1'b1;
		repeat (8) @(posedge clk);
		check(32'(hv), 32'h0000_0000);
		st(8'hD0);
		stp <= 1'b0;
		repeat (8) @(posedge clk);
		st(8'hD0);
		wr(OFF_STATUS, 32'h0000_0010);
		// Protection lifted in debug, then mass erase
		dbg <= 1'b1;
		repeat (6) @(posedge clk);
		wr(OFF_PROT, 32'h0000_0000);
		dbg <= 1'b0;
		rd(OFF_PROT, d);
		check(32'(d[7:0]), 32'h0000_0000);
		cmd(16'h0000, CMD_MASS_ERASE);
		st(8'h80);
		check(32'(hv), 32'h0000_0001);
		done();
		st(8'hC0);
		check(32'(acmd), 32'(CMD_MASS_ERASE));
		$display("done: erase");
		spc <= 1'b1;
		repeat (6) @(posedge clk);
		for (int m = 0; m < 3; m++) begin
			cmd(md[m], CMD_MARGIN);
			done();
			check(32'(ml), 32'(lv[m]));
		end
		spc <= 1'b0;
		$display("done: margin");
		// Secured part and key machine
		boot(1'b1);
		wr(OFF_CLKDIV, 32'h0000_0010);
		nsrc <= 1'b1;
		two(16'h0000, OFF_CMD, 32'(CMD_PROGRAM));
		st(8'hD0);
		nsrc <= 1'b0;
		keyseq();
		check(32'(sst), 32'h0000_0002);
		rd(OFF_PROT, d);
		check(32'(d[7:0]), 32'h0000_0080);
		for (int j = 0; j < 6; j++) begin
			boot(1'b1);
			spc <= (j == 5);
			dbg <= (j == 5);
			wr(OFF_CONFIG, 32'h0000_0001);
			case (j)
				0: wr(OFF_KEYWR, {14'h0000, 2'b01, keys[31:16]});
				1: wr(OFF_KEYWR, 32'h0000_0000);
				2: wr(OFF_KEYWR, 32'h0000_FFFF);
				3: wr(OFF_KEYWR, 32'h0000_1111);
				4: begin
					wr(OFF_KEYWR, {16'h0000, keys[15:0]});
					wr(OFF_CONFIG, 32'h0000_0000);
				end
				default: repeat (6) @(posedge clk);
			endcase
			check(32'(klk), (j == 5) ? 32'h0000_0000 : 32'h0000_0001);
			keyseq();
			check(32'(sst), 32'h0000_0000);
			spc <= 1'b0;
			dbg <= 1'b0;
		end
		$display("done: security");
		tally_and_finish();
	end

	// Command, then a non-launch write
	task automatic cmd_tail(input logic [7:0] a);
		two(16'h0000, OFF_CMD, 32'(CMD_PROGRAM));
		wr(a, 32'h0000_0000);
	endtask
endmodule
`default_nettype wire
